// >>> hdl/ee_defs.vh
// Shared constants for the two-wire memory slave front end
`ifndef EE_DEFS_VH
`define EE_DEFS_VH

// ----------------------------------------------------------------
// Bus framing
// ----------------------------------------------------------------
`define EE_BYTE_BITS 4'h8
`define EE_RW_BIT 0
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_SEL_MSB 3
`define EE_SEL_LSB 1

// ----------------------------------------------------------------
// Array and page buffer
// ----------------------------------------------------------------
`define EE_ADDR_W 13
`define EE_PAGE_W 5
`define EE_PAGE_N 6'h20
`define EE_PROG_W 21

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_CLK_MHZ 100
`define EE_PROG_TIME_US 3000
`define EE_TMR_W 19

// ----------------------------------------------------------------
// Buffering and synchroniser
// ----------------------------------------------------------------
`define EE_FIFO_DEPTH 16
`define EE_FIFO_AW 4
`define EE_SYNC_W 6
`define EE_SYNC_RST 6'h30

`endif

// >>> hdl/ee_sync.v
// Two-flop synchroniser for pins entering the system clock domain
module ee_sync #(
   parameter W = 6,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire i_clk,
   input wire i_rstn,
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

// First stage feeds only the second stage
always @(posedge i_clk or negedge i_rstn)
begin
   if (!i_rstn)
   begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
   end
   else
   begin
      meta_r <= i_d;
      sync_r <= meta_r;
   end
end

assign o_q = sync_r;

endmodule

// >>> hdl/ee_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
module ee_fifo #(
   parameter W = 21,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_wr_valid,
   output wire o_wr_ready,
   input wire [W-1:0] i_wr_data,
   output wire o_rd_valid,
   input wire i_rd_ready,
   output wire [W-1:0] o_rd_data
);

reg [W-1:0] mem_r [0:DEPTH-1];
reg [AW:0] wp_r;
reg [AW:0] rp_r;
wire full_w;
wire empty_w;
wire push_w;
wire pop_w;

// Extra pointer bit tells full from empty
assign full_w = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
assign empty_w = (wp_r == rp_r);
assign o_wr_ready = ~full_w;
assign o_rd_valid = ~empty_w;
assign o_rd_data = mem_r[rp_r[AW-1:0]];
assign push_w = i_wr_valid & ~full_w;
assign pop_w = i_rd_ready & ~empty_w;

always @(posedge i_clk)
begin
   if (push_w)
      mem_r[wp_r[AW-1:0]] <= i_wr_data;
end

always @(posedge i_clk or negedge i_rstn)
begin
   if (!i_rstn)
   begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
   end
   else
   begin
      if (push_w)
         wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
      if (pop_w)
         rp_r <= rp_r + {{AW{1'b0}}, 1'b1};
   end
end

endmodule

// >>> hdl/ee_slave.v
// Two-wire serial slave front end of a byte memory with page buffer
//
// Notes on behaviour
// - Bytes move most significant bit first in both directions.
// - Data changes only while clock is low; stable while high.
// - Idle bus sits high; our data output is released.
// - Data falling with clock high is a start; address matching restarts.
// - Data rising with clock high is a stop; operation ends.
// - One clock pulse per data bit.
// - Transmitter releases after eight bits; receiver pulls low on ninth clock.
// - No acknowledge while programming is in progress.
// - In reads, sample master acknowledge on ninth clock; low means next byte.
// - Missing master acknowledge ends sending; wait for stop.
// - Upper four address bits must equal the device type code.
// - Next three address bits must equal the address-select pins.
// - Eighth address bit set means read, clear means write.
// - Write protect high refuses writes; low permits them.
// - Unconnected address-select pins read low.
// - A write takes up to 32 bytes into the page buffer.
// - Word pointer covers the array; 13 bits for the larger variant.
// - Programming lasts about 3 ms; device busy meanwhile.
// - Serial clock up to 100 kHz standard, 400 kHz fast.
// - Write sends two word-address bytes, high first, before data.
// - Stop after a write starts programming; requests ignored until done.
// - Protected: address bytes acknowledged, data not, no programming started.
// - Page pointer wraps inside the page; extra bytes overwrite.
`include "ee_defs.vh"

module ee_slave #(
   parameter [3:0] P_DEV_TYPE = 4'h5, // Arbitrary value
   parameter [`EE_TMR_W-1:0] P_PROG_CYC = `EE_PROG_TIME_US * `EE_CLK_MHZ
) (
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_scl,
   input wire i_sda,
   input wire i_addr_select_bit0,
   input wire i_addr_select_bit1,
   input wire i_addr_select_bit2,
   input wire i_write_protect,
   input wire [7:0] i_rd_data,
   input wire i_prog_ready,
   output wire o_sda_o,
   output wire o_sda_oe,
   output wire [`EE_ADDR_W-1:0] o_rd_addr,
   output wire o_prog_valid,
   output wire [`EE_ADDR_W-1:0] o_prog_addr,
   output wire [7:0] o_prog_data,
   output wire o_busy
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RX = 3'h1;
localparam [2:0] ST_RXACK = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_TXACK = 3'h4;
localparam [2:0] ST_WAIT = 3'h5;

localparam [1:0] K_SADDR = 2'h0;
localparam [1:0] K_HI = 2'h1;
localparam [1:0] K_LO = 2'h2;
localparam [1:0] K_DATA = 2'h3;

// ----------------------------------------------------------------
// Pin synchronisers and bus events
// ----------------------------------------------------------------
wire [`EE_SYNC_W-1:0] sync_w;
wire scl_s;
wire sda_s;
wire wp_s;
wire [2:0] sel_s;
reg scl_q_r;
reg sda_q_r;

// Pulldowns make floating select and protect pins low at the board
ee_sync #(.W(`EE_SYNC_W), .RST_VAL(`EE_SYNC_RST)) u_sync (
   .i_clk(i_sys_clk),
   .i_rstn(i_rstn),
   .i_d({i_scl, i_sda, i_write_protect,
         i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0}),
   .o_q(sync_w)
);

assign scl_s = sync_w[5];
assign sda_s = sync_w[4];
assign wp_s = sync_w[3];
assign sel_s = sync_w[2:0];

wire start_w = scl_s & scl_q_r & sda_q_r & ~sda_s;
wire stop_w = scl_s & scl_q_r & ~sda_q_r & sda_s;
// Sync plus edge flop cost three cycles, small against any legal clock phase
wire scl_rise = scl_s & ~scl_q_r;
wire scl_fall = ~scl_s & scl_q_r;

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [2:0] state_r;
reg [1:0] kind_r;
reg [3:0] cnt_r;
reg [7:0] sh_r;
reg to_tx_r;
reg mack_r;
reg sda_oe_r;
reg sda_o_r;
reg wr_pend_r;
reg prog_go_r;
reg prog_r;
reg [`EE_ADDR_W-1:0] ptr_r;
reg [`EE_ADDR_W-1:0] rd_addr_r;
reg [`EE_PAGE_N-1:0] valid_r;
reg [7:0] pbuf_r [0:`EE_PAGE_N-1];
reg [5:0] flush_idx_r;
reg [`EE_TMR_W-1:0] timer_r;
reg [`EE_ADDR_W-`EE_PAGE_W-1:0] base_r;
reg prog_valid_r;
reg [`EE_PROG_W-1:0] prog_word_r;

wire fifo_wr_ready;
wire fifo_rd_valid;
wire [`EE_PROG_W-1:0] fifo_rd_data;
wire fifo_rd_ready = ~prog_valid_r | i_prog_ready;
wire flush_live = prog_r & (flush_idx_r != `EE_PAGE_N);
wire push_w = flush_live & valid_r[flush_idx_r[4:0]] & fifo_wr_ready;
wire quiet_w = ~start_w & ~stop_w;
wire byte_end = quiet_w & scl_fall & (cnt_r == `EE_BYTE_BITS);

// Busy device never matches, so the address goes unanswered
wire match_w = (sh_r[`EE_TYPE_MSB:`EE_TYPE_LSB] == P_DEV_TYPE)
   && (sh_r[`EE_SEL_MSB:`EE_SEL_LSB] == sel_s)
   && ~prog_r && ~prog_go_r;

wire store_w = (state_r == ST_RX) & byte_end & (kind_r == K_DATA) & ~wp_s;
wire load_w = quiet_w & scl_fall &
   (((state_r == ST_RXACK) & to_tx_r) | ((state_r == ST_TXACK) & mack_r));

// ----------------------------------------------------------------
// Page buffer data
// ----------------------------------------------------------------
always @(posedge i_sys_clk)
begin
   if (store_w)
      pbuf_r[ptr_r[`EE_PAGE_W-1:0]] <= sh_r;
end

// ----------------------------------------------------------------
// Bus state machine
// ----------------------------------------------------------------
always @(posedge i_sys_clk or negedge i_rstn)
begin
   if (!i_rstn)
   begin
      // Idle bus levels, so no false start or stop follows reset
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      state_r <= ST_IDLE;
      kind_r <= K_SADDR;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      to_tx_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
      wr_pend_r <= 1'b0;
      prog_go_r <= 1'b0;
      ptr_r <= {`EE_ADDR_W{1'b0}};
      rd_addr_r <= {`EE_ADDR_W{1'b0}};
      valid_r <= {`EE_PAGE_N{1'b0}};
   end
   else
   begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      prog_go_r <= 1'b0;
      rd_addr_r <= ptr_r;
      if (push_w)
         valid_r[flush_idx_r[4:0]] <= 1'b0;
      if (start_w)
      begin
         state_r <= ST_RX;
         kind_r <= K_SADDR;
         cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end
      else if (stop_w)
      begin
         state_r <= ST_IDLE;
         sda_oe_r <= 1'b0;
         wr_pend_r <= 1'b0;
         if (wr_pend_r)
            prog_go_r <= 1'b1;
      end
      else
      begin
         case (state_r)
            ST_RX:
            begin
               if (scl_rise)
               begin
                  sh_r <= {sh_r[6:0], sda_s};
                  cnt_r <= cnt_r + 4'h1;
               end
               else if (byte_end)
               begin
                  cnt_r <= 4'h0;
                  state_r <= ST_RXACK;
                  sda_oe_r <= 1'b1;
                  case (kind_r)
                     K_SADDR:
                     begin
                        if (!match_w)
                        begin
                           sda_oe_r <= 1'b0;
                           state_r <= ST_WAIT;
                        end
                        else
                        begin
                           to_tx_r <= sh_r[`EE_RW_BIT];
                           kind_r <= K_HI;
                        end
                     end
                     K_HI:
                     begin
                        ptr_r[`EE_ADDR_W-1:8] <= sh_r[`EE_ADDR_W-9:0];
                        kind_r <= K_LO;
                     end
                     K_LO:
                     begin
                        ptr_r[7:0] <= sh_r;
                        kind_r <= K_DATA;
                     end
                     default:
                     begin
                        if (wp_s)
                        begin
                           sda_oe_r <= 1'b0;
                           state_r <= ST_WAIT;
                        end
                        else
                        begin
                           valid_r[ptr_r[`EE_PAGE_W-1:0]] <= 1'b1;
                           wr_pend_r <= 1'b1;
                           // Page-local increment: overflow overwrites
                           ptr_r[`EE_PAGE_W-1:0] <= ptr_r[`EE_PAGE_W-1:0] + 5'h01;
                        end
                     end
                  endcase
               end
            end
            ST_RXACK:
            begin
               if (scl_fall)
               begin
                  sda_oe_r <= 1'b0;
                  if (to_tx_r)
                  begin
                     sh_r <= i_rd_data;
                     sda_oe_r <= ~i_rd_data[7];
                     ptr_r <= ptr_r + {{(`EE_ADDR_W-1){1'b0}}, 1'b1};
                     state_r <= ST_TX;
                  end
                  else
                     state_r <= ST_RX;
               end
            end
            ST_TX:
            begin
               if (scl_rise)
                  cnt_r <= cnt_r + 4'h1;
               else if (byte_end)
               begin
                  cnt_r <= 4'h0;
                  sda_oe_r <= 1'b0;
                  mack_r <= 1'b0;
                  state_r <= ST_TXACK;
               end
               else if (scl_fall)
               begin
                  sh_r <= {sh_r[6:0], 1'b0};
                  sda_oe_r <= ~sh_r[6];
               end
            end
            ST_TXACK:
            begin
               if (scl_rise)
                  mack_r <= ~sda_s;
               else if (load_w)
               begin
                  sh_r <= i_rd_data;
                  sda_oe_r <= ~i_rd_data[7];
                  ptr_r <= ptr_r + {{(`EE_ADDR_W-1){1'b0}}, 1'b1};
                  state_r <= ST_TX;
               end
               else if (scl_fall)
                  state_r <= ST_WAIT;
            end
            ST_WAIT:
               sda_oe_r <= 1'b0;
            ST_IDLE:
               sda_oe_r <= 1'b0;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
end

// ----------------------------------------------------------------
// Programming cycle: flush page buffer, hold busy for the cycle time
// ----------------------------------------------------------------
always @(posedge i_sys_clk or negedge i_rstn)
begin
   if (!i_rstn)
   begin
      prog_r <= 1'b0;
      flush_idx_r <= 6'h00;
      timer_r <= {`EE_TMR_W{1'b0}};
      base_r <= {(`EE_ADDR_W-`EE_PAGE_W){1'b0}};
   end
   else if (prog_go_r)
   begin
      prog_r <= 1'b1;
      flush_idx_r <= 6'h00;
      timer_r <= P_PROG_CYC;
      base_r <= ptr_r[`EE_ADDR_W-1:`EE_PAGE_W];
   end
   else if (prog_r)
   begin
      if (timer_r != {`EE_TMR_W{1'b0}})
         timer_r <= timer_r - {{(`EE_TMR_W-1){1'b0}}, 1'b1};
      // A full FIFO stalls the flush here
      if (flush_live && (push_w || !valid_r[flush_idx_r[4:0]]))
         flush_idx_r <= flush_idx_r + 6'h01;
      if (!flush_live && timer_r == {`EE_TMR_W{1'b0}} && !fifo_rd_valid && !prog_valid_r)
         prog_r <= 1'b0;
   end
end

// ----------------------------------------------------------------
// Write stream toward the array
// ----------------------------------------------------------------
ee_fifo #(.W(`EE_PROG_W), .DEPTH(`EE_FIFO_DEPTH), .AW(`EE_FIFO_AW)) u_fifo (
   .i_clk(i_sys_clk),
   .i_rstn(i_rstn),
   .i_wr_valid(push_w),
   .o_wr_ready(fifo_wr_ready),
   .i_wr_data({base_r, flush_idx_r[4:0], pbuf_r[flush_idx_r[4:0]]}),
   .o_rd_valid(fifo_rd_valid),
   .i_rd_ready(fifo_rd_ready),
   .o_rd_data(fifo_rd_data)
);

always @(posedge i_sys_clk or negedge i_rstn)
begin
   if (!i_rstn)
   begin
      prog_valid_r <= 1'b0;
      prog_word_r <= {`EE_PROG_W{1'b0}};
   end
   else if (fifo_rd_ready)
   begin
      prog_valid_r <= fifo_rd_valid;
      prog_word_r <= fifo_rd_data;
   end
end

assign o_sda_o = sda_o_r;
assign o_sda_oe = sda_oe_r;
assign o_rd_addr = rd_addr_r;
assign o_prog_valid = prog_valid_r;
assign o_prog_addr = prog_word_r[`EE_PROG_W-1:8];
assign o_prog_data = prog_word_r[7:0];
assign o_busy = prog_r;

endmodule

// >>> tb/ee_slave_asserts.sv
// Concurrent checks on the two-wire memory slave front end
`include "ee_defs.vh"
module ee_slave_asserts #(
   parameter [`EE_TMR_W-1:0] P_PROG_CYC = 200
) (
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_scl,
   input wire i_sda,
   input wire i_addr_select_bit0,
   input wire i_addr_select_bit1,
   input wire i_addr_select_bit2,
   input wire i_write_protect,
   input wire [7:0] i_rd_data,
   input wire i_prog_ready,
   input wire o_sda_o,
   input wire o_sda_oe,
   input wire [`EE_ADDR_W-1:0] o_rd_addr,
   input wire o_prog_valid,
   input wire [`EE_ADDR_W-1:0] o_prog_addr,
   input wire [7:0] o_prog_data,
   input wire o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------
   // Busy length counter
   // --------
   reg [19:0] busy_cnt_r;
   always @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         busy_cnt_r <= 20'h0;
      else if (o_busy)
         busy_cnt_r <= busy_cnt_r + 20'h1;
      else
         busy_cnt_r <= 20'h0;
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   // --------
   // Properties
   // --------
   property p_oe_when_low;
      $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2) && $past(i_scl, 6);
   endproperty
   a_oe_when_low: assert property (p_oe_when_low) else $error("sda drive moved badly");
   property p_oe_hold;
      $rose(o_sda_oe) |-> o_sda_oe [*8];
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("sda drive too short");
   property p_prog_hold;
      o_prog_valid && !i_prog_ready |=> o_prog_valid && $stable(o_prog_addr)
         && $stable(o_prog_data);
   endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("prog word dropped");
   property p_busy_quiet;
      o_busy |-> !o_sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
   property p_prog_busy;
      o_prog_valid |-> o_busy;
   endproperty
   a_prog_busy: assert property (p_prog_busy) else $error("prog word when idle");
   property p_busy_start;
      $rose(o_busy) |-> i_scl && i_sda && !$past(i_sda, 9);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy without stop");
   property p_wp_block;
      $rose(o_busy) |-> !i_write_protect;
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("programming while protected");
   property p_busy_len;
      $fell(o_busy) |-> busy_cnt_r >= P_PROG_CYC - 1;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy too short");
endmodule

bind ee_slave ee_slave_asserts #(.P_PROG_CYC(P_PROG_CYC)) ee_slave_asserts_i (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
   .i_addr_select_bit0(i_addr_select_bit0), .i_addr_select_bit1(i_addr_select_bit1),
   .i_addr_select_bit2(i_addr_select_bit2), .i_write_protect(i_write_protect),
   .i_rd_data(i_rd_data), .i_prog_ready(i_prog_ready), .o_sda_o(o_sda_o),
   .o_sda_oe(o_sda_oe), .o_rd_addr(o_rd_addr), .o_prog_valid(o_prog_valid),
   .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data), .o_busy(o_busy));

// >>> tb/ee_i2c_master.sv
// Two-wire bus master model driving the serial clock and framing
module ee_i2c_master (
   input wire i_sys_clk,
   input wire i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Four sys cycles per phase, an 80 ns clock; slave output settles before rise
   localparam int Q = 2;
   initial
   begin
      o_scl = 1'b1; // Idle bus high
      o_sda_oe = 1'b0;
   end
   task automatic q;
      repeat (Q) @(posedge i_sys_clk);
   endtask
   // Also a repeated start when the clock is low
   task automatic start;
      q;
      o_sda_oe <= 1'b0;
      q;
      o_scl <= 1'b1;
      q;
      q;
      o_sda_oe <= 1'b1;
      q;
      q;
      o_scl <= 1'b0;
   endtask
   task automatic stop;
      q;
      o_sda_oe <= 1'b1;
      q;
      o_scl <= 1'b1;
      q;
      q;
      o_sda_oe <= 1'b0;
      q;
      q;
   endtask
   // Nine clocks, first bit is the MSB, a 1 releases the line
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--)
      begin
         q;
         o_sda_oe <= !d[i]; // Data moves only with clock low
         q;
         o_scl <= 1'b1;
         q;
         q;
         r[i] = i_sda;
         o_scl <= 1'b0;
      end
   endtask
endmodule

// >>> tb/test_ee_slave.sv
// Self-checking bench for the two-wire memory slave front end
`include "ee_defs.vh"
module test_ee_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [3:0] DEV_TYPE = 4'h5; // Arbitrary type code
   localparam [`EE_TMR_W-1:0] PROG_CYC = 200;
   logic clk = 1'b0, rstn = 1'b0, wp = 1'b0, prog_ready = 1'b1;
   logic [2:0] sel = 3'h0;
   logic m_scl, m_oe, sda_o, sda_oe, prog_valid, busy, a;
   logic [12:0] rd_addr, prog_addr;
   logic [7:0] prog_data, d;
   logic [7:0] mem [0:8191];
   int err_count = 0, checked = 0;
   // Pull-up unless a party pulls low
   wire sda_line = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
   wire [7:0] rd_data = mem[rd_addr];
   ee_slave #(.P_DEV_TYPE(DEV_TYPE), .P_PROG_CYC(PROG_CYC)) ee_slave_i (
      .i_sys_clk(clk), .i_rstn(rstn), .i_scl(m_scl), .i_sda(sda_line),
      .i_addr_select_bit0(sel[0]), .i_addr_select_bit1(sel[1]),
      .i_addr_select_bit2(sel[2]), .i_write_protect(wp), .i_rd_data(rd_data),
      .i_prog_ready(prog_ready), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .o_rd_addr(rd_addr), .o_prog_valid(prog_valid), .o_prog_addr(prog_addr),
      .o_prog_data(prog_data), .o_busy(busy));
   ee_i2c_master ee_i2c_master_i (.i_sys_clk(clk), .i_sda(sda_line), .o_scl(m_scl),
      .o_sda_oe(m_oe));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (prog_valid && prog_ready)
         mem[prog_addr] <= prog_data;
   // --------
   // Helpers
   // --------
   task chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_word(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task sla(input logic [3:0] t, input logic [2:0] s, input logic rw);
      logic [8:0] r;
      ee_i2c_master_i.start;
      ee_i2c_master_i.xfer({t, s, rw, 1'b1}, r);
      a = !r[0];
   endtask
   task wr(input logic [7:0] v);
      logic [8:0] r;
      ee_i2c_master_i.xfer({v, 1'b1}, r);
      a = !r[0];
   endtask
   task rd(input logic mack);
      logic [8:0] r;
      ee_i2c_master_i.xfer({8'hff, !mack}, r);
      d = r[8:1];
   endtask
   task final_report;
      $display("checks=%0d errors=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // --------
   // Scenarios
   // --------
   task t_reset;
      chk_bit(sda_oe, 1'b0);
      chk_bit(busy, 1'b0);
      chk_bit(prog_valid, 1'b0);
      chk_word(rd_addr, 13'h0);
   endtask
   task t_select;
      sel <= 3'h5;
      for (int s = 0; s < 8; s++)
      begin
         sla(DEV_TYPE, s[2:0], 1'b0);
         ee_i2c_master_i.stop;
         chk_bit(a, s == 5);
      end
      sla(DEV_TYPE ^ 4'h8, 3'h5, 1'b0);
      ee_i2c_master_i.stop;
      chk_bit(a, 1'b0);
      sel <= 3'h0;
      sla(DEV_TYPE, 3'h0, 1'b0);
      ee_i2c_master_i.stop;
      chk_bit(a, 1'b1);
   endtask
   task t_page;
      prog_ready <= 1'b0;
      sla(DEV_TYPE, 3'h0, 1'b0);
      chk_bit(a, 1'b1);
      wr(8'hea);
      chk_bit(a, 1'b1);
      wr(8'hde);
      chk_bit(a, 1'b1);
      for (int k = 0; k < 34; k++)
      begin
         wr(8'h80 + k[7:0]);
         chk_bit(a, 1'b1);
      end
      ee_i2c_master_i.stop;
      repeat (8) @(posedge clk);
      chk_bit(busy, 1'b1);
      sla(DEV_TYPE, 3'h0, 1'b0);
      ee_i2c_master_i.stop;
      chk_bit(a, 1'b0);
      // Stalled array keeps the stream and busy pending
      repeat (300) @(posedge clk);
      chk_bit(busy, 1'b1);
      prog_ready <= 1'b1;
      for (int n = 0; n < 2000 && busy !== 1'b0; n++)
         @(posedge clk);
      chk_bit(busy, 1'b0);
      for (int k = 2; k < 34; k++)
         chk_word(mem[13'h0ac0 + (30 + k) % 32], 13'h80 + k);
   endtask
   task t_read;
      sla(DEV_TYPE, 3'h0, 1'b0);
      wr(8'hff);
      wr(8'hff);
      sla(DEV_TYPE, 3'h0, 1'b1);
      chk_bit(a, 1'b1);
      rd(1'b1);
      chk_word(d, 13'hff ^ 13'h5a);
      rd(1'b0);
      chk_word(d, 13'h00 ^ 13'h5a);
      repeat (12) @(posedge clk);
      chk_bit(sda_oe, 1'b0);
      ee_i2c_master_i.stop;
      sla(DEV_TYPE, 3'h0, 1'b1);
      rd(1'b0);
      ee_i2c_master_i.stop;
      chk_word(d, 13'h01 ^ 13'h5a);
   endtask
   task t_protect;
      wp <= 1'b1;
      sla(DEV_TYPE, 3'h0, 1'b0);
      chk_bit(a, 1'b1);
      wr(8'h00);
      chk_bit(a, 1'b1);
      wr(8'h10);
      chk_bit(a, 1'b1);
      wr(8'h33);
      chk_bit(a, 1'b0);
      ee_i2c_master_i.stop;
      repeat (20) @(posedge clk);
      chk_bit(busy, 1'b0);
      wp <= 1'b0;
      chk_word(mem[16], 13'h10 ^ 13'h5a);
   endtask
   initial
   begin
      for (int i = 0; i < 8192; i++)
         mem[i] = i[7:0] ^ 8'h5a;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      t_reset;
      t_select;
      t_page;
      t_read;
      t_protect;
      final_report;
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      err_count++;
      final_report;
   end
endmodule
